// [design/tbrt_pkg.sv]
// Constants and carrier types for the two-button reboot timer.
// Assumes a 20 MHz system clock and synchronous button inputs.
package tbrt_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int DELAY_LONG_MS = 12500;
  localparam int DELAY_SHORT_MS = 7500;
  localparam int DELAY_MIN_MS = 1000;
  localparam int DELAY_MAX_MS = 20000;
  localparam int PULSE_MS = 400;
  localparam int DELAY_LONG_TICKS = DELAY_LONG_MS * 1000 / TICK_PERIOD_US;
  localparam int DELAY_SHORT_TICKS = DELAY_SHORT_MS * 1000 / TICK_PERIOD_US;
  localparam int DELAY_MIN_TICKS = DELAY_MIN_MS * 1000 / TICK_PERIOD_US;
  localparam int DELAY_MAX_TICKS = DELAY_MAX_MS * 1000 / TICK_PERIOD_US;
  localparam int PULSE_TICKS = PULSE_MS * 1000 / TICK_PERIOD_US;
  localparam int CNT_W = 16;
  localparam int SET_W = 15;
  localparam int DIV_W = 32;

  typedef enum logic [1:0] {
    TBRT_STANDBY,
    TBRT_DELAY,
    TBRT_PULSE,
    TBRT_WAIT_RELEASE
  } tbrt_state_e;

  typedef struct packed {
    logic above_release;
    logic below_detect;
  } tbrt_supply_s;
endpackage

// [design/tbrt_timer.sv]
// Two-button reboot timer: tick divider, one counter shared by delay and pulse, output driver.
// Assumes buttons and qualifier synchronous to clk_sys_in, already debounced.
`timescale 1ns/10ps
module tbrt_timer #(
  parameter int TICK_CYCLES = tbrt_pkg::TICK_CYCLES,
  parameter bit ADJUSTABLE = 1'b0,
  parameter bit PUSH_PULL = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Buttons, active low
  input wire logic button_a_n_in,
  input wire logic button_b_n_in,
  // Delay setting
  input wire logic delay_select_in,
  input wire logic [tbrt_pkg::SET_W-1:0] timing_resistor_pin_in,
  // Supply qualifier
  input wire tbrt_pkg::tbrt_supply_s supply_qualifier_in,
  // Reboot output pin
  output logic reboot_out_n_out,
  output logic reboot_oe_out
);

  localparam logic [tbrt_pkg::CNT_W-1:0] LONG_T =
    tbrt_pkg::CNT_W'(tbrt_pkg::DELAY_LONG_TICKS);
  localparam logic [tbrt_pkg::CNT_W-1:0] SHORT_T =
    tbrt_pkg::CNT_W'(tbrt_pkg::DELAY_SHORT_TICKS);
  localparam logic [tbrt_pkg::CNT_W-1:0] MIN_T =
    tbrt_pkg::CNT_W'(tbrt_pkg::DELAY_MIN_TICKS);
  localparam logic [tbrt_pkg::CNT_W-1:0] MAX_T =
    tbrt_pkg::CNT_W'(tbrt_pkg::DELAY_MAX_TICKS);
  localparam logic [tbrt_pkg::CNT_W-1:0] PULSE_T =
    tbrt_pkg::CNT_W'(tbrt_pkg::PULSE_TICKS);
  localparam logic [tbrt_pkg::DIV_W-1:0] DIV_LAST =
    tbrt_pkg::DIV_W'(TICK_CYCLES - 1);
  localparam logic [tbrt_pkg::CNT_W-1:0] SET_SCALE =
    tbrt_pkg::CNT_W'(1000 / tbrt_pkg::TICK_PERIOD_US);

  tbrt_pkg::tbrt_state_e state_r;
  logic [tbrt_pkg::DIV_W-1:0] div_r;
  logic [tbrt_pkg::CNT_W-1:0] cnt_r;
  logic [tbrt_pkg::CNT_W-1:0] target_r;
  logic [tbrt_pkg::CNT_W-1:0] target_nxt;
  logic [tbrt_pkg::CNT_W-1:0] set_ticks;
  logic sel_r;
  logic both_low;
  logic tick;
  logic delay_done;
  logic pulse_done;

  assign both_low = !button_a_n_in && !button_b_n_in;
  assign tick = (div_r == DIV_LAST);
  assign delay_done = tick && (cnt_r == target_r - 1'b1);
  assign pulse_done = tick && (cnt_r == PULSE_T - 1'b1);
  assign set_ticks = tbrt_pkg::CNT_W'(timing_resistor_pin_in) * SET_SCALE;

  // Out-of-range settings clamp rather than wrap the counter
  always_comb begin
    if (ADJUSTABLE) begin
      if (set_ticks < MIN_T) begin
        target_nxt = MIN_T;
      end else if (set_ticks > MAX_T) begin
        target_nxt = MAX_T;
      end else begin
        target_nxt = set_ticks;
      end
    end else begin
      target_nxt = delay_select_in ? LONG_T : SHORT_T;
    end
  end

  // Sequence control
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= tbrt_pkg::TBRT_STANDBY;
    end else begin
      unique case (state_r)
        tbrt_pkg::TBRT_STANDBY: begin
          if (both_low && supply_qualifier_in.above_release &&
              !supply_qualifier_in.below_detect) begin
            state_r <= tbrt_pkg::TBRT_DELAY;
          end
        end
        tbrt_pkg::TBRT_DELAY: begin
          if (!both_low || supply_qualifier_in.below_detect) begin
            state_r <= tbrt_pkg::TBRT_STANDBY;
          end else if (delay_done) begin
            state_r <= tbrt_pkg::TBRT_PULSE;
          end
        end
        tbrt_pkg::TBRT_PULSE: begin
          // Button release does not end the pulse; both_low only picks the next state at pulse end
          if (supply_qualifier_in.below_detect) begin
            state_r <= tbrt_pkg::TBRT_STANDBY;
          end else if (pulse_done) begin
            state_r <= both_low ? tbrt_pkg::TBRT_WAIT_RELEASE
                                : tbrt_pkg::TBRT_STANDBY;
          end
        end
        tbrt_pkg::TBRT_WAIT_RELEASE: begin
          if (!both_low) begin
            state_r <= tbrt_pkg::TBRT_STANDBY;
          end
        end
      endcase
    end
  end

  // Tick divider stands still in standby to mimic a stopped oscillator
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_r <= '0;
    end else if (state_r == tbrt_pkg::TBRT_STANDBY ||
                 state_r == tbrt_pkg::TBRT_WAIT_RELEASE) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // Shared tick counter for delay and pulse
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        tbrt_pkg::TBRT_DELAY: begin
          if (!both_low || supply_qualifier_in.below_detect || delay_done) begin
            cnt_r <= '0;
          end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        tbrt_pkg::TBRT_PULSE: begin
          if (supply_qualifier_in.below_detect || pulse_done) begin
            cnt_r <= '0;
          end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          cnt_r <= '0;
        end
      endcase
    end
  end

  // Delay target latched at sequence start
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      target_r <= SHORT_T;
      sel_r <= 1'b0;
    end else if (state_r == tbrt_pkg::TBRT_STANDBY) begin
      target_r <= target_nxt;
      sel_r <= delay_select_in;
    end
  end

  // Output driver
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reboot_out_n_out <= 1'b1;
      reboot_oe_out <= PUSH_PULL;
    end else if (state_r == tbrt_pkg::TBRT_DELAY && both_low &&
                 !supply_qualifier_in.below_detect && delay_done) begin
      reboot_out_n_out <= 1'b0;
      reboot_oe_out <= 1'b1;
    end else if (state_r == tbrt_pkg::TBRT_PULSE &&
                 (supply_qualifier_in.below_detect || pulse_done)) begin
      reboot_out_n_out <= 1'b1;
      reboot_oe_out <= PUSH_PULL;
    end else if (state_r != tbrt_pkg::TBRT_PULSE) begin
      reboot_out_n_out <= 1'b1;
      reboot_oe_out <= PUSH_PULL;
    end
  end

  // Helper: length of the low phase, in clock cycles
  logic [31:0] low_len_r;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_len_r <= '0;
    end else if (!reboot_out_n_out) begin
      low_len_r <= low_len_r + 32'h0000_0001;
    end else begin
      low_len_r <= '0;
    end
  end

  // Helper: cycles spent in the current delay
  logic [31:0] dly_len_r;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dly_len_r <= '0;
    end else if (state_r == tbrt_pkg::TBRT_DELAY) begin
      dly_len_r <= dly_len_r + 32'h0000_0001;
    end else begin
      dly_len_r <= '0;
    end
  end

  chk_start_both_low: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_STANDBY) ##1 (state_r == tbrt_pkg::TBRT_DELAY)
    |-> $past(both_low) && $past(supply_qualifier_in.above_release))
    else $error("delay started without both buttons low and supply good");

  chk_fixed_target: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (!ADJUSTABLE && state_r == tbrt_pkg::TBRT_DELAY)
    |-> target_r == (sel_r ? LONG_T : SHORT_T))
    else $error("fixed delay target does not match captured select");

  chk_select_held: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_DELAY) ##1 (state_r != tbrt_pkg::TBRT_STANDBY)
    |-> $stable(target_r))
    else $error("delay target changed during sequence");

  chk_adj_range: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (ADJUSTABLE && state_r == tbrt_pkg::TBRT_DELAY)
    |-> target_r >= MIN_T && target_r <= MAX_T)
    else $error("adjustable delay outside range");

  chk_standby_idle: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_DELAY && !both_low)
    |=> state_r == tbrt_pkg::TBRT_STANDBY ##1 (cnt_r == '0 && div_r == '0))
    else $error("counters not idle after button release");

  chk_tick_only: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (cnt_r != $past(cnt_r) && cnt_r != '0) |-> $past(tick))
    else $error("counter advanced without a tick");

  chk_uv_abort: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_DELAY && supply_qualifier_in.below_detect)
    |=> cnt_r == '0 && reboot_out_n_out && state_r == tbrt_pkg::TBRT_STANDBY)
    else $error("undervoltage in delay did not reset it");

  chk_pulse_start: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $fell(reboot_out_n_out)
    |-> state_r == tbrt_pkg::TBRT_PULSE && cnt_r == '0 &&
        dly_len_r == $past(dly_len_r) + 32'h1 &&
        dly_len_r == TICK_CYCLES * $past(target_r))
    else $error("output fell out of step with delay end");

  chk_pulse_len: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(reboot_out_n_out) && !$past(supply_qualifier_in.below_detect)
    |-> $past(low_len_r) + 32'h1 == TICK_CYCLES * tbrt_pkg::PULSE_TICKS)
    else $error("reboot pulse length wrong");

  chk_pulse_hold: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_PULSE && !both_low && !pulse_done &&
     !supply_qualifier_in.below_detect) |=> state_r == tbrt_pkg::TBRT_PULSE)
    else $error("pulse cut short by button release");

  chk_uv_pulse: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_PULSE && supply_qualifier_in.below_detect)
    |=> cnt_r == '0 && reboot_out_n_out)
    else $error("undervoltage in pulse did not reset it");

  chk_idle_drive: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reboot_out_n_out |-> reboot_oe_out == PUSH_PULL)
    else $error("driver state wrong while released");

  chk_no_repeat: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_WAIT_RELEASE && both_low)
    |=> state_r == tbrt_pkg::TBRT_WAIT_RELEASE)
    else $error("second pulse without button release");

  chk_start_gated: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_STANDBY &&
     (!supply_qualifier_in.above_release || supply_qualifier_in.below_detect))
    |=> state_r == tbrt_pkg::TBRT_STANDBY)
    else $error("delay started without supply release");

  chk_counters_idle: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_STANDBY || state_r == tbrt_pkg::TBRT_WAIT_RELEASE)
    |-> cnt_r == '0)
    else $error("counter not idle outside a sequence");

  chk_idle_output: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r != tbrt_pkg::TBRT_PULSE)
    |-> reboot_out_n_out && reboot_oe_out == PUSH_PULL)
    else $error("output driven while pulse counter idle");

  // Release must land on the very edge that ends the count
  chk_pulse_release: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (state_r == tbrt_pkg::TBRT_PULSE && pulse_done && !supply_qualifier_in.below_detect)
    |=> reboot_out_n_out && reboot_oe_out == PUSH_PULL &&
        state_r != tbrt_pkg::TBRT_PULSE)
    else $error("output not released at pulse end");

endmodule

// [bench/tbrt_button_model.sv]
// Button pair and system reset input facing two reboot timers.
// Assumes press requests from the bench, synchronous to clk_sys_in.
`timescale 1ns/10ps
module tbrt_button_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Press requests
  input wire logic press_a_in,
  input wire logic press_b_in,
  // Timer pins
  input wire logic out_f_in,
  input wire logic oe_f_in,
  input wire logic out_a_in,
  input wire logic oe_a_in,
  // Buttons and reset levels seen by the system
  output logic button_a_n_out,
  output logic button_b_n_out,
  output logic rst_f_out,
  output logic rst_a_out
);
  // Released contacts read high through the pull-ups
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      button_a_n_out <= 1'b1;
      button_b_n_out <= 1'b1;
    end else begin
      button_a_n_out <= !press_a_in;
      button_b_n_out <= !press_b_in;
    end
  end
  // Undriven line rests on the pull-up
  assign rst_f_out = oe_f_in ? out_f_in : 1'b1;
  assign rst_a_out = oe_a_in ? out_a_in : 1'b1;
endmodule

// [bench/test_two_button_reboot_timer.sv]
// Bench for the reboot timer: fixed open-drain and adjustable push-pull.
// Assumes a short tick so that whole delays fit in one run.
`timescale 1ns/10ps
module test_two_button_reboot_timer;
  localparam int TK = 2;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic press_a = 1'b0;
  logic press_b = 1'b0;
  logic sel = 1'b1;
  logic [tbrt_pkg::SET_W-1:0] tim = 15'h03e8;
  tbrt_pkg::tbrt_supply_s qual = 2'b10;
  logic btn_a, btn_b, out_f, oe_f, out_a, oe_a, rst_f, rst_a;
  int n_mismatch = 0;
  int check_count = 0;

  initial begin
    forever #25 clk_sys_in = !clk_sys_in;
  end

  tbrt_timer #(.TICK_CYCLES(TK)) tbrt_timer_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .button_a_n_in(btn_a),
    .button_b_n_in(btn_b), .delay_select_in(sel), .timing_resistor_pin_in(tim),
    .supply_qualifier_in(qual), .reboot_out_n_out(out_f), .reboot_oe_out(oe_f));
  tbrt_timer #(.TICK_CYCLES(TK), .ADJUSTABLE(1'b1), .PUSH_PULL(1'b1)) tbrt_timer_adj_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .button_a_n_in(btn_a),
    .button_b_n_in(btn_b), .delay_select_in(sel), .timing_resistor_pin_in(tim),
    .supply_qualifier_in(qual), .reboot_out_n_out(out_a), .reboot_oe_out(oe_a));
  tbrt_button_model tbrt_button_model_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .press_a_in(press_a),
    .press_b_in(press_b), .out_f_in(out_f), .oe_f_in(oe_f), .out_a_in(out_a),
    .oe_a_in(oe_a), .button_a_n_out(btn_a), .button_b_n_out(btn_b),
    .rst_f_out(rst_f), .rst_a_out(rst_a));

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s exp %0d got %0d", what, exp, got);
      n_mismatch++;
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task press(input logic a, input logic b);
    @(posedge clk_sys_in);
    press_a <= a;
    press_b <= b;
  endtask

  // Cycles from both buttons low to the fall, then the low time
  task meas(input bit adj, tog, rel, uv, output int n, output int m);
    n = 0;
    m = 0;
    press(1'b1, 1'b1);
    @(posedge clk_sys_in);
    do begin
      @(posedge clk_sys_in);
      if (tog && n == 100)
        sel <= !sel;
      #1;
      n++;
    end while ((adj ? rst_a : rst_f) === 1'b1 && n < 30000);
    do begin
      @(posedge clk_sys_in);
      if (rel && m == 0)
        press_a <= 1'b0;
      if (uv && m == 10)
        qual <= 2'b01;
      #1;
      m++;
    end while ((adj ? rst_a : rst_f) === 1'b0 && m < 1000);
  endtask

  task quiet(input int cyc, output int lows);
    lows = 0;
    repeat (cyc) begin
      @(posedge clk_sys_in);
      #1;
      if (rst_a !== 1'b1)
        lows++;
    end
  endtask

  task t_idle;
    chk("oe_f", 1'b0, oe_f);
    chk("oe_a", 1'b1, oe_a);
    chk("out_a", 1'b1, out_a);
    $display("t_idle done");
  endtask

  task t_long;
    int n, m;
    meas(1'b0, 1'b1, 1'b1, 1'b0, n, m);
    chk("long delay", TK * tbrt_pkg::DELAY_LONG_TICKS + 1, n);
    chk("long width", TK * tbrt_pkg::PULSE_TICKS, m);
    chk("oe_f after", 1'b0, oe_f);
    press(1'b0, 1'b0);
    $display("t_long done");
  endtask

  task t_short;
    int n, m;
    press(1'b1, 1'b1);
    repeat (1000) @(posedge clk_sys_in);
    press(1'b1, 1'b0);
    meas(1'b0, 1'b0, 1'b0, 1'b0, n, m);
    chk("short delay", TK * tbrt_pkg::DELAY_SHORT_TICKS + 1, n);
    chk("short width", TK * tbrt_pkg::PULSE_TICKS, m);
    press(1'b0, 1'b0);
    $display("t_short done");
  endtask

  task t_adj;
    int n, m, lows, l2;
    @(posedge clk_sys_in);
    qual <= 2'b00;
    press(1'b1, 1'b1);
    quiet(2500, lows);
    chk("no release level", 0, lows);
    press(1'b0, 1'b0);
    qual <= 2'b10;
    press(1'b1, 1'b1);
    quiet(1000, lows);
    @(posedge clk_sys_in);
    qual <= 2'b01;
    // Long enough that an ignored abort would reach the pulse
    quiet(1100, l2);
    chk("abort in delay", 0, lows + l2);
    press(1'b0, 1'b0);
    qual <= 2'b10;
    repeat (3) @(posedge clk_sys_in);
    meas(1'b1, 1'b0, 1'b0, 1'b0, n, m);
    chk("adj delay", TK * tbrt_pkg::DELAY_MIN_TICKS + 1, n);
    chk("adj width", TK * tbrt_pkg::PULSE_TICKS, m);
    quiet(2500, lows);
    chk("held buttons", 0, lows);
    press(1'b0, 1'b0);
    // Short setting clamps up to the minimum delay
    tim <= 15'h0064;
    repeat (3) @(posedge clk_sys_in);
    meas(1'b1, 1'b0, 1'b0, 1'b1, n, m);
    chk("adj clamp", TK * tbrt_pkg::DELAY_MIN_TICKS + 1, n);
    // Qualifier is seen one edge after it is raised
    chk("pulse cut", 12, m);
    chk("oe_a after", 1'b1, oe_a);
    press(1'b0, 1'b0);
    qual <= 2'b10;
    $display("t_adj done");
  endtask

  initial begin
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    t_idle;
    t_long;
    t_short;
    t_adj;
    test_done;
  end

  initial begin
    repeat (90000) @(posedge clk_sys_in);
    $display("BAD watchdog exp 0 got 1");
    n_mismatch++;
    test_done;
  end
endmodule
